// ===== logic/clock_frequency_counter.v
/*
 * Clock frequency counter with an APB register slave. Counts edges of a
 * selected test clock over a window timed by core_clk, scales the count by
 * the programmed reference frequency and reports status and result.
 * Assumes core_clk is the reference clock and that the test clocks are
 * slower than half of it; they are sampled through a two-flop stage.
 */
`timescale 1ns/1ps
`include "freq_counter_consts.vh"

// Summary of operation
// - After a start the counter waits the programmed 3-bit number of reference periods plus one, reset value 1, before counting.
// - The counting window lasts 980 ns rounded up to whole reference periods (1 us at 50 ns) times two to the 4-bit interval setting, 8 after reset.
// - Any write of a nonzero code to the 8-bit source selector starts a new measurement of the chosen clock; 0x00 returns to idle.
// - Source codes 0x01 to 0x0d pick one test clock input each and 0x00 picks none.
// - Status shows bit 12 while awaiting the test clock, bit 8 while running, bit 4 when done.
// - On completion bit 24 flags too fast, bit 20 too slow, bit 16 fail and bit 0 pass.
// - Status bit 28 is set when the test clock shows no rising edge for 256 reference periods inside the counting window.
// - The result holds whole kHz in bits 29 to 5 and a 5-bit fraction in bits 4 to 0.
// - A 25-bit minimum pass frequency in kHz sets the lower pass limit.
// - A 25-bit maximum pass frequency in kHz, reset to all ones, sets the upper pass limit.
module clock_frequency_counter #(
	parameter [19:0] WINDOW_BASE_CYCLES = `WINDOW_BASE_CYCLES
) (
	input wire core_clk,
	input wire rstn,
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [`SRC_COUNT-1:0] test_clocks
);

	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_DELAY = 6'h02;
	localparam [5:0] ST_WAIT = 6'h04;
	localparam [5:0] ST_RUN = 6'h08;
	localparam [5:0] ST_CALC = 6'h10;
	localparam [5:0] ST_DONE = 6'h20;

	function in_map;
		input [11:0] a;
		begin
			in_map = (a == `ADDR_REFERENCE_KHZ) || (a == `ADDR_PASS_MIN_KHZ) ||
				(a == `ADDR_PASS_MAX_KHZ) || (a == `ADDR_COUNT_START_DELAY) ||
				(a == `ADDR_MEASURE_WINDOW_EXPONENT) ||
				(a == `ADDR_MEASURED_CLOCK_SELECT) || (a == `ADDR_MEASURE_STATUS) ||
				(a == `ADDR_MEASURED_FREQUENCY);
		end
	endfunction

	reg [19:0] reference_khz_q;
	reg [24:0] pass_min_khz_q;
	reg [24:0] pass_max_khz_q;
	reg [2:0] count_start_delay_q;
	reg [3:0] measure_window_exponent_q;
	reg [7:0] measured_clock_select_q;
	reg [5:0] state_q;
	reg [2:0] delay_cnt_q;
	reg [19:0] win_cnt_q;
	reg [23:0] edge_cnt_q;
	reg [7:0] gap_cnt_q;
	reg [19:0] rem_q;
	reg [48:0] num_q;
	reg [5:0] step_q;
	reg [29:0] result_q;
	reg stopped_q;
	reg fast_q;
	reg slow_q;
	reg pass_q;
	reg fail_q;
	reg tclk_meta_q;
	reg tclk_sync_q;
	reg tclk_prev_q;

	wire access = psel & penable & pready;
	wire wr_en = access & pwrite;
	wire start = wr_en && (paddr == `ADDR_MEASURED_CLOCK_SELECT);
	// with the default base the longest window still fits 20 bits
	wire [19:0] win_len = WINDOW_BASE_CYCLES << measure_window_exponent_q;
	wire test_edge = tclk_sync_q & ~tclk_prev_q;
	wire [20:0] trial = {rem_q, num_q[48]};
	wire take = (trial >= {1'b0, win_len});
	wire [20:0] trial_sub = trial - {1'b0, win_len};
	wire [43:0] product = edge_cnt_q * reference_khz_q;
	wire [24:0] whole_khz_part = result_q[29:5];
	wire [31:0] status_word;
	reg sel_clk;

	// code 0 and codes past the last source select a quiet line
	always @* begin
		sel_clk = 1'b0;
		if (measured_clock_select_q != `SRC_NONE && measured_clock_select_q <= `SRC_LAST) begin
			sel_clk = test_clocks[measured_clock_select_q[3:0]];
		end
	end

	// the test clock must stay below half of core_clk or edges are lost
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tclk_meta_q <= 1'b0;
			tclk_sync_q <= 1'b0;
			tclk_prev_q <= 1'b0;
		end else begin
			tclk_meta_q <= sel_clk;
			tclk_sync_q <= tclk_meta_q;
			tclk_prev_q <= tclk_sync_q;
		end
	end

	// config registers; a write lands on the edge where pready is seen high
	// writes to status and result fall to the default branch and are dropped
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			reference_khz_q <= `RST_REFERENCE_KHZ;
			pass_min_khz_q <= `RST_PASS_MIN_KHZ;
			pass_max_khz_q <= `RST_PASS_MAX_KHZ;
			count_start_delay_q <= `RST_COUNT_START_DELAY;
			measure_window_exponent_q <= `RST_MEASURE_WINDOW_EXPONENT;
			measured_clock_select_q <= `RST_MEASURED_CLOCK_SELECT;
		end else if (wr_en) begin
			case (paddr)
				`ADDR_REFERENCE_KHZ: begin
					reference_khz_q <= pwdata[19:0];
				end
				`ADDR_PASS_MIN_KHZ: begin
					pass_min_khz_q <= pwdata[24:0];
				end
				`ADDR_PASS_MAX_KHZ: begin
					pass_max_khz_q <= pwdata[24:0];
				end
				`ADDR_COUNT_START_DELAY: begin
					count_start_delay_q <= pwdata[2:0];
				end
				`ADDR_MEASURE_WINDOW_EXPONENT: begin
					measure_window_exponent_q <= pwdata[3:0];
				end
				`ADDR_MEASURED_CLOCK_SELECT: begin
					measured_clock_select_q <= pwdata[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	// measurement sequencer
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			delay_cnt_q <= 3'h0;
			win_cnt_q <= 20'h0;
			edge_cnt_q <= 24'h0;
			gap_cnt_q <= 8'h0;
			rem_q <= 20'h0;
			num_q <= 49'h0;
			step_q <= 6'h0;
			result_q <= 30'h0;
			stopped_q <= 1'b0;
			fast_q <= 1'b0;
			slow_q <= 1'b0;
			pass_q <= 1'b0;
			fail_q <= 1'b0;
		end else if (start) begin
			// a new selection aborts whatever was in flight
			// restart wins over a flag the old run would raise in the same cycle
			stopped_q <= 1'b0;
			fast_q <= 1'b0;
			slow_q <= 1'b0;
			pass_q <= 1'b0;
			fail_q <= 1'b0;
			delay_cnt_q <= 3'h0;
			if (pwdata[7:0] == `SRC_NONE) begin
				state_q <= ST_IDLE;
			end else begin
				state_q <= ST_DELAY;
			end
		end else begin
			case (state_q)
				ST_IDLE: begin
				end
				ST_DELAY: begin
					// lets the selector and the sync stage settle
					if (delay_cnt_q >= count_start_delay_q) begin
						state_q <= ST_WAIT;
					end else begin
						delay_cnt_q <= delay_cnt_q + 3'h1;
					end
				end
				// a code past the last source never sees an edge; write 0 to leave
				ST_WAIT: begin
					if (test_edge) begin
						state_q <= ST_RUN;
						win_cnt_q <= 20'h0;
						edge_cnt_q <= 24'h0;
						gap_cnt_q <= 8'h0;
					end
				end
				ST_RUN: begin
					win_cnt_q <= win_cnt_q + 20'h1;
					if (test_edge) begin
						edge_cnt_q <= edge_cnt_q + 24'h1;
						gap_cnt_q <= 8'h0;
					end else begin
						gap_cnt_q <= gap_cnt_q + 8'h1;
					end
					// a stall beats the window end, so a dead clock never passes
					if (!test_edge && gap_cnt_q == `STALL_LIMIT) begin
						stopped_q <= 1'b1;
						fail_q <= 1'b1;
						result_q <= 30'h0;
						state_q <= ST_DONE;
					end else if (win_cnt_q == win_len - 20'h1) begin
						// the count is final one cycle later; fold that edge in
						state_q <= ST_CALC;
						rem_q <= 20'h0;
						step_q <= 6'h0;
					end
				end
				ST_CALC: begin
					// bit-serial restoring divide: edges*ref_khz*32 / window cycles
					if (step_q == 6'h0 && num_q != {product, 5'h0}) begin
						num_q <= {product, {`FRACTION_BITS{1'b0}}};
						step_q <= 6'h0;
						rem_q <= 20'h0;
					end
					if (step_q == 6'h0 && num_q != {product, 5'h0}) begin
					end else if (step_q == `DIV_STEPS) begin
						state_q <= ST_DONE;
						if (num_q[48:30] != 19'h0) begin
							result_q <= 30'h3fffffff;
						end else begin
							result_q <= num_q[29:0];
						end
					end else begin
						rem_q <= take ? trial_sub[19:0] : trial[19:0];
						num_q <= {num_q[47:0], take};
						step_q <= step_q + 6'h1;
					end
				end
				// the verdict looks at whole kHz only; the fraction is ignored
				ST_DONE: begin
					if (!stopped_q && !fast_q && !slow_q && !pass_q && !fail_q) begin
						fast_q <= whole_khz_part > pass_max_khz_q;
						slow_q <= whole_khz_part < pass_min_khz_q;
						pass_q <= !(whole_khz_part > pass_max_khz_q) &&
							!(whole_khz_part < pass_min_khz_q);
						fail_q <= (whole_khz_part > pass_max_khz_q) ||
							(whole_khz_part < pass_min_khz_q);
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// verdict flags appear one cycle after done, or with done on a stall; fast/slow only mean something then
	assign status_word = {3'h0, stopped_q, 3'h0, fast_q & state_q[5], 3'h0,
		slow_q & state_q[5], 3'h0, fail_q & state_q[5], 3'h0,
		state_q[1] | state_q[2], 3'h0, state_q[3] | state_q[4], 3'h0,
		state_q[5], 3'h0, pass_q & state_q[5]};

	// apb: one wait state, so pready and prdata both come from flops
	// status is captured the cycle before pready, so it is one cycle old
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= !in_map(paddr);
			prdata <= 32'h0;
			if (!pwrite && in_map(paddr)) begin
				case (paddr)
					`ADDR_REFERENCE_KHZ: prdata <= {12'h0, reference_khz_q};
					`ADDR_PASS_MIN_KHZ: prdata <= {7'h0, pass_min_khz_q};
					`ADDR_PASS_MAX_KHZ: prdata <= {7'h0, pass_max_khz_q};
					`ADDR_COUNT_START_DELAY: prdata <= {29'h0, count_start_delay_q};
					`ADDR_MEASURE_WINDOW_EXPONENT: prdata <= {28'h0, measure_window_exponent_q};
					`ADDR_MEASURED_CLOCK_SELECT: prdata <= {24'h0, measured_clock_select_q};
					`ADDR_MEASURE_STATUS: prdata <= status_word;
					`ADDR_MEASURED_FREQUENCY: prdata <= {2'h0, result_q};
					default: prdata <= 32'h0;
				endcase
			end
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
	end

endmodule

// ===== logic/freq_counter_consts.vh
/*
 * Constants for the clock frequency counter: register offsets, field
 * positions, reset values, source codes and timing counts.
 * Assumes inclusion by the counter module and the bench; definitions only.
 */
`ifndef FREQ_COUNTER_CONSTS_VH
`define FREQ_COUNTER_CONSTS_VH

`define CORE_CLK_PERIOD_NS 50
`define WINDOW_UNIT_NS 980
`define WINDOW_BASE_CYCLES ((`WINDOW_UNIT_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define STALL_LIMIT 8'hff

`define ADDR_REFERENCE_KHZ 12'h080
`define ADDR_PASS_MIN_KHZ 12'h084
`define ADDR_PASS_MAX_KHZ 12'h088
`define ADDR_COUNT_START_DELAY 12'h08c
`define ADDR_MEASURE_WINDOW_EXPONENT 12'h090
`define ADDR_MEASURED_CLOCK_SELECT 12'h094
`define ADDR_MEASURE_STATUS 12'h098
`define ADDR_MEASURED_FREQUENCY 12'h09c

`define RST_REFERENCE_KHZ 20'h00000
`define RST_PASS_MIN_KHZ 25'h0000000
`define RST_PASS_MAX_KHZ 25'h1ffffff
`define RST_COUNT_START_DELAY 3'h1
`define RST_MEASURE_WINDOW_EXPONENT 4'h8
`define RST_MEASURED_CLOCK_SELECT 8'h00

`define STAT_TEST_CLOCK_STOPPED 28
`define STAT_FAST 24
`define STAT_SLOW 20
`define STAT_FAIL 16
`define STAT_WAITING 12
`define STAT_RUNNING 8
`define STAT_DONE 4
`define STAT_PASS 0

`define SRC_NONE 8'h00
`define SRC_LAST 8'h0d
`define SRC_COUNT 14

`define FRACTION_BITS 5
`define DIV_STEPS 6'd49

`endif

// ===== dv/fc_props.sv
/* apb-side assertions for the clock frequency counter
   assumes the counter's top ports only; bound below */
`timescale 1ns/1ps
module fc_props (
	input wire core_clk,
	input wire rstn,
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	wire st = pready && !pwrite && paddr == 12'h098;
	wire [31:0] d = prdata;
	pready_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered");
	pready_pulse_a: assert property (pready |=> !pready ##1 !pready)
		else $error("pready too long");
	phase_onehot_a: assert property (st |-> $onehot0({d[12], d[8], d[4]}))
		else $error("two phase bits");
	status_rsvd_a: assert property (st |-> (d & ~32'h11111111) == 32'h0)
		else $error("reserved status bit");
	verdict_done_a: assert property (st && (d[0] || d[16]) |-> d[4] && !(d[0] && d[16]))
		else $error("verdict without done");
	fast_slow_a: assert property (st && (d[24] || d[20]) |-> d[16] && d[4])
		else $error("fast or slow not failing");
	stopped_a: assert property (st && d[28] |-> !d[8] && !d[12])
		else $error("stopped while active");
	unmapped_a: assert property (pready && paddr > 12'h09c |-> pslverr && d == 32'h0)
		else $error("unmapped not refused");
	cover property (st && d[0]);
	cover property (st && d[28]);
	cover property (pready && pslverr);
endmodule
bind clock_frequency_counter fc_props u_props (.core_clk(core_clk), .rstn(rstn), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));

// ===== dv/tb.sv
/* self-checking bench for the clock frequency counter
   assumes a 20 MHz reference and a 2.5 MHz test clock */
`timescale 1ns/1ps
`include "freq_counter_consts.vh"
module tb;
	logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tclk = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, rd;
	logic [31:0] prdata;
	logic pready, pslverr, err;
	logic [13:0] tc_en = 14'h0;
	wire [13:0] test_clocks = {14{tclk}} & tc_en;
	int miscompares = 0, n_compared = 0;
	always #25 core_clk = ~core_clk;
	always #200 tclk = ~tclk;
	clock_frequency_counter #(.WINDOW_BASE_CYCLES(20'h1)) DUT (.core_clk(core_clk), .rstn(rstn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .test_clocks(test_clocks));
	task complete_run;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one idle cycle first, so psel is never assigned twice in one step
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1 && ++n < 20);
		// answer taken at the edge pready is seen, then released by nba
		rd = prdata;
		err = pslverr;
		if (pready !== 1'b1) begin
			miscompares++;
			$display("ERROR %0t no pready", $time);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] dat);
		xfer(1'b1, a, dat);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	// second read lets the verdict land one cycle after done
	task wait_done;
		int n;
		n = 0;
		do xfer(1'b0, `ADDR_MEASURE_STATUS, 32'h0); while (rd[4] !== 1'b1 && ++n < 400);
		chk({31'h0, rd[4]}, 32'h1);
		xfer(1'b0, `ADDR_MEASURE_STATUS, 32'h0);
	endtask
	task t_regs;
		rdc(`ADDR_REFERENCE_KHZ, 32'h0);
		rdc(`ADDR_PASS_MIN_KHZ, 32'h0);
		rdc(`ADDR_PASS_MAX_KHZ, 32'h1ffffff);
		rdc(`ADDR_COUNT_START_DELAY, 32'h1);
		rdc(`ADDR_MEASURE_WINDOW_EXPONENT, 32'h8);
		rdc(`ADDR_MEASURED_CLOCK_SELECT, 32'h0);
		rdc(`ADDR_MEASURED_FREQUENCY, 32'h0);
		wr(`ADDR_COUNT_START_DELAY, 32'hffffffff);
		rdc(`ADDR_COUNT_START_DELAY, 32'h7);
		wr(`ADDR_MEASURE_STATUS, 32'hffffffff);
		rdc(`ADDR_MEASURE_STATUS, 32'h0);
		rdc(12'h0a0, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask
	task t_codes;
		wr(`ADDR_MEASURE_WINDOW_EXPONENT, 32'h4);
		for (int c = 1; c <= 13; c++) begin
			tc_en <= 14'h1 << c;
			wr(`ADDR_MEASURED_CLOCK_SELECT, 32'(c));
			wait_done;
			chk(rd & 32'h10010011, 32'h11);
		end
	endtask
	task t_measure(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] verdict);
		tc_en <= 14'h0020;
		wr(`ADDR_PASS_MIN_KHZ, lo);
		wr(`ADDR_PASS_MAX_KHZ, hi);
		wr(`ADDR_MEASURED_CLOCK_SELECT, 32'h5);
		rdc(`ADDR_MEASURE_STATUS, 32'h1000);
		repeat (20) @(posedge core_clk);
		rdc(`ADDR_MEASURE_STATUS, 32'h100);
		wait_done;
		chk(rd, verdict | 32'h10);
		xfer(1'b0, `ADDR_MEASURED_FREQUENCY, 32'h0);
		chk(32'(rd[29:5] > 25'h974 && rd[29:5] < 25'ha14), 32'h1);
	endtask
	task t_stop;
		tc_en <= 14'h0040;
		// the stall limit must run out before the window does
		wr(`ADDR_MEASURE_WINDOW_EXPONENT, 32'ha);
		wr(`ADDR_MEASURED_CLOCK_SELECT, 32'h6);
		repeat (40) @(posedge core_clk);
		tc_en <= 14'h0;
		wait_done;
		chk(rd, 32'h10010010);
		rdc(`ADDR_MEASURED_FREQUENCY, 32'h0);
		wr(`ADDR_MEASURED_CLOCK_SELECT, 32'h0);
		rdc(`ADDR_MEASURE_STATUS, 32'h0);
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		t_regs;
		t_codes;
		wr(`ADDR_REFERENCE_KHZ, 32'h4e20);
		wr(`ADDR_MEASURE_WINDOW_EXPONENT, 32'h8);
		t_measure(32'h960, 32'ha28, 32'h1);
		t_measure(32'hbb8, 32'h1ffffff, 32'h110000);
		t_measure(32'h0, 32'h7d0, 32'h1010000);
		t_stop;
		complete_run;
	end
	initial begin
		repeat (30000) @(posedge core_clk);
		miscompares++;
		complete_run;
	end
endmodule
